// file: hdl/mprc_pkg.sv
/*
 * Shared constants, bit timing and state codes of the repeater core.
 * Assumes a single 20 MHz master clock and an active-low reset.
 */
// Notes on behaviour
// [R01] Single active port repeats to other enabled ports
// [R02] Repeated data also drives expansion serial line
// [R03] At least 56 preamble bits before delimiter
// [R04] Over 65536 bits transmitting: lock out 96
// [R05] Jabber lockout state visible as status output
// [R06] Fragments under 96 bits extended by jam
// [R07] Asynchronous bus mode may extend to 97
// [R08] Partitioned port transmits but receiver ignored
// [R09] Partition after SQE active over 2048 bits
// [R10] Partition after 32 consecutive collided transmit attempts
// [R11] Standard: reconnect on clean 512+ bit packet
// [R12] Alternate: only clean transmitted packets reconnect
// [R13] Partition logic separate for every port
// [R14] Transmit and one-port-left collisions jam correctly
// [R15] Each port individually switchable off
// [R16] Low reset returns all logic to default
// [R17] System supplies 20 MHz master clock
// [R18] Expansion request low while device is active
// [R19] Arbiter collision input starts own jam
// [R20] Per-port bit picks standard or alternate
// [R21] Bit time is two master clock cycles
package mprc_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS = 50;
    localparam int BIT_NS = 100;
    localparam int CYC_PER_BIT = BIT_NS / CLK_NS;
    localparam int PREAMBLE_BITS = 56;
    localparam int FRAG_BITS = 96;
    localparam int FRAG_BITS_ASYNC = 97;
    localparam int JABBER_BITS = 65536;
    localparam int LOCKOUT_BITS = 96;
    localparam int SQE_BITS = 2048;
    localparam int COL_ATTEMPTS = 32;
    localparam int RECON_BITS = 512;
    localparam int DEFAULT_PORTS = 14;

    // ****************************************************************
    // Repeater states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_DATA = 3'b010,
        ST_JAM = 3'b011,
        ST_LOCK = 3'b100
    } mprc_state_t;
endpackage

// file: hdl/mprc_ptn_if.sv
/*
 * Per-port link between the repeater core and one partition unit.
 * Assumes both ends run on the core clock.
 */
interface mprc_ptn_if;
    logic bit_tick;
    logic enabled;
    logic alt;
    logic rx_act;
    logic sqe;
    logic tx_on;
    logic collided;
    logic frame_end;
    logic partitioned;
    modport core (
        output bit_tick, enabled, alt, rx_act, sqe, tx_on, collided,
        output frame_end,
        input partitioned
    );
    modport unit (
        input bit_tick, enabled, alt, rx_act, sqe, tx_on, collided,
        input frame_end,
        output partitioned
    );
endinterface

// file: hdl/mprc_ptn_unit.sv
/*
 * Partition and reconnection state of one network port.
 * Assumes frame_end pulses once at the end of each repeater frame.
 */
module mprc_ptn_unit (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Core link
    mprc_ptn_if.unit p
);
    typedef struct packed {
        logic [12:0] sqe_cnt;
        logic [5:0] att_cnt;
        logic [9:0] len_cnt;
        logic tx_seen;
        logic rx_seen;
        logic col_seen;
        logic rx_prev;
        logic part;
    } mprc_ptn_state_t;

    mprc_ptn_state_t r_reg;
    mprc_ptn_state_t r_next;
    logic end_evt;

    // The core ignores a partitioned receiver, so its own carrier end
    // closes the frame for reconnection
    assign end_evt = p.frame_end || (r_reg.part && r_reg.rx_prev
        && !p.rx_act && !r_reg.tx_seen); // [R11]

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        r_next = r_reg;
        r_next.rx_prev = p.rx_act;
        // Stuck SQE counts only while the port is enabled
        if (p.sqe && p.enabled)
        begin
            if (p.bit_tick && r_reg.sqe_cnt <= 13'(mprc_pkg::SQE_BITS))
                r_next.sqe_cnt = r_reg.sqe_cnt + 13'h0001;
        end
        else
            r_next.sqe_cnt = '0;
        if (r_reg.sqe_cnt > 13'(mprc_pkg::SQE_BITS))
            r_next.part = 1'b1; // [R09]
        if (p.tx_on)
            r_next.tx_seen = 1'b1;
        if (p.rx_act)
            r_next.rx_seen = 1'b1;
        if (p.collided)
            r_next.col_seen = 1'b1;
        if ((p.tx_on || p.rx_act) && p.bit_tick
            && r_reg.len_cnt <= 10'(mprc_pkg::RECON_BITS))
            r_next.len_cnt = r_reg.len_cnt + 10'h001;
        if (end_evt)
        begin
            if (r_reg.tx_seen && p.enabled)
            begin
                if (r_reg.col_seen)
                begin
                    r_next.att_cnt = r_reg.att_cnt + 6'h01;
                    if (r_reg.att_cnt == 6'(mprc_pkg::COL_ATTEMPTS - 1))
                    begin
                        r_next.part = 1'b1; // [R10]
                        r_next.att_cnt = '0;
                    end
                end
                else
                    r_next.att_cnt = '0;
            end
            // Alternate rule ignores received packets
            if (r_reg.part && !r_reg.col_seen
                && r_reg.len_cnt > 10'(mprc_pkg::RECON_BITS)
                && (r_reg.tx_seen || (!p.alt && r_reg.rx_seen)))
                r_next.part = 1'b0; // [R11] [R12] [R20]
            r_next.tx_seen = 1'b0;
            r_next.rx_seen = 1'b0;
            r_next.col_seen = 1'b0;
            r_next.len_cnt = '0;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            r_reg <= '0; // [R16]
        else
            r_reg <= r_next;
    end

    assign p.partitioned = r_reg.part; // [R13]

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_sqe_partition: assert property ( // [R09]
        @(posedge clock_i) disable iff (!nrst_i)
        r_reg.sqe_cnt > 13'(mprc_pkg::SQE_BITS) |=> r_reg.part)
        else $error("stuck SQE did not partition the port");
    a_attempt_clear: assert property ( // [R10]
        @(posedge clock_i) disable iff (!nrst_i)
        p.frame_end && p.enabled && r_reg.tx_seen && !r_reg.col_seen
        |=> r_reg.att_cnt == 6'h00)
        else $error("clean transmit did not clear attempt count");
    a_alt_rx_ignored: assert property ( // [R12]
        @(posedge clock_i) disable iff (!nrst_i)
        end_evt && p.alt && r_reg.part && !r_reg.tx_seen
        |=> r_reg.part)
        else $error("alternate rule reconnected on receive only");
endmodule

// file: hdl/mprc_core.sv
/*
 * Repeater core: picks the single receiving port, regenerates preamble,
 * repeats to all other enabled ports and the expansion bus, jams on
 * collision, extends fragments and cuts jabber.
 * Assumes synchronous port inputs and one 20 MHz clock.
 */
module mprc_core #(
    parameter int PORTS = mprc_pkg::DEFAULT_PORTS,
    parameter int JABBER_BITS = mprc_pkg::JABBER_BITS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Network ports
    input wire logic [PORTS-1:0] rx_crs_i,
    input wire logic [PORTS-1:0] rx_dat_i,
    input wire logic [PORTS-1:0] col_i,
    input wire logic [PORTS-1:0] sqe_i,
    output logic [PORTS-1:0] tx_en_o,
    output logic [PORTS-1:0] tx_dat_o,
    // Port control and status
    input wire logic [PORTS-1:0] port_en_i,
    input wire logic [PORTS-1:0] alt_algo_i,
    output logic [PORTS-1:0] port_partitioned_o,
    output logic tx_jabber_lockout_o,
    // Expansion bus
    input wire logic async_mode_i,
    output logic exp_req_n_o,
    input wire logic exp_ack_n_i,
    input wire logic exp_col_n_i,
    input wire logic expansion_serial_line_i,
    output logic expansion_serial_line_o,
    output logic expansion_serial_line_oe_o,
    input wire logic exp_jam_i,
    output logic exp_jam_o,
    output logic exp_jam_oe_o
);
    localparam int BW = $clog2(JABBER_BITS) + 2;
    localparam int IW = $clog2(PORTS);
    localparam int LOCK_CYC =
        mprc_pkg::LOCKOUT_BITS * mprc_pkg::CYC_PER_BIT;

    if (PORTS < 2 || JABBER_BITS < mprc_pkg::FRAG_BITS_ASYNC)
    begin : g_bad_cfg
        $error("mprc_core: PORTS or JABBER_BITS out of range");
    end

    typedef struct packed {
        mprc_pkg::mprc_state_t st;
        logic div;
        logic fdiv;
        logic [IW-1:0] src;
        logic from_exp;
        logic [BW-1:0] bits;
        logic [6:0] lock_cnt;
        logic [PORTS-1:0] tx_en;
        logic tx_dat;
        logic req;
    } mprc_core_state_t;

    mprc_core_state_t r_reg;
    mprc_core_state_t r_next;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [IW:0] count_ones(input logic [PORTS-1:0] v);
        logic [IW:0] c;
        c = '0;
        for (int i = 0; i < PORTS; i++)
            c = c + (IW+1)'(v[i]);
        return c;
    endfunction

    function automatic logic [IW-1:0] first_set(input logic [PORTS-1:0] v);
        logic [IW-1:0] k;
        k = '0;
        for (int i = PORTS - 1; i >= 0; i--)
            if (v[i])
                k = IW'(i);
        return k;
    endfunction

    // ****************************************************************
    // Port activity
    // ****************************************************************
    logic [PORTS-1:0] part;
    logic [PORTS-1:0] live;
    logic [PORTS-1:0] coll;
    logic [IW:0] n_live;
    logic any_col;
    logic tick;
    logic exp_in;
    logic busy;
    logic src_crs;
    logic src_dat;
    logic [BW-1:0] frag;

    // Partitioned or disabled receivers take no part in repeating
    assign live = rx_crs_i & port_en_i & ~part; // [R08] [R15]
    assign coll = col_i & port_en_i & ~part;
    assign n_live = count_ones(live);
    assign tick = r_reg.div; // [R21]
    assign exp_in = !exp_ack_n_i && !r_reg.req;
    assign any_col = (|coll) || !exp_col_n_i // [R19]
        || (n_live > (IW+1)'(1)) || (r_reg.from_exp && exp_jam_i);
    assign busy = r_reg.st == mprc_pkg::ST_PRE
        || r_reg.st == mprc_pkg::ST_DATA || r_reg.st == mprc_pkg::ST_JAM;
    assign src_crs = r_reg.from_exp ? exp_in : rx_crs_i[r_reg.src];
    assign src_dat = r_reg.from_exp ? expansion_serial_line_i
        : rx_dat_i[r_reg.src];
    // Asynchronous bus timing may cost one extra jam bit
    assign frag = async_mode_i ? BW'(mprc_pkg::FRAG_BITS_ASYNC)
        : BW'(mprc_pkg::FRAG_BITS); // [R07]

    // ****************************************************************
    // Repeater sequence
    // ****************************************************************
    always_comb
    begin
        r_next = r_reg;
        r_next.div = ~r_reg.div;
        r_next.fdiv = ~r_reg.fdiv;
        if (tick && busy)
            r_next.bits = r_reg.bits + BW'(1);
        case (r_reg.st)
            mprc_pkg::ST_IDLE:
            begin
                r_next.bits = '0;
                r_next.div = 1'b0;
                r_next.tx_dat = 1'b1;
                r_next.from_exp = 1'b0;
                if (n_live > (IW+1)'(1) || |coll)
                    r_next.st = mprc_pkg::ST_JAM; // [R14]
                else if (n_live == (IW+1)'(1))
                begin
                    r_next.src = first_set(live); // [R01]
                    r_next.st = mprc_pkg::ST_PRE;
                end
                else if (exp_in)
                begin
                    r_next.from_exp = 1'b1;
                    r_next.st = mprc_pkg::ST_DATA;
                end
            end
            mprc_pkg::ST_PRE:
            begin
                // Fresh 1010 pattern, received preamble is discarded
                if (tick)
                begin
                    r_next.tx_dat = ~r_reg.tx_dat;
                    if (any_col)
                        r_next.st = mprc_pkg::ST_JAM;
                    else if (r_reg.bits == BW'(mprc_pkg::PREAMBLE_BITS - 1))
                        r_next.st = mprc_pkg::ST_DATA; // [R03]
                end
            end
            mprc_pkg::ST_DATA:
            begin
                if (tick)
                begin
                    r_next.tx_dat = src_dat;
                    if (any_col && !r_reg.from_exp)
                        r_next.st = mprc_pkg::ST_JAM; // [R14]
                    else if (r_reg.from_exp && exp_jam_i)
                        r_next.st = mprc_pkg::ST_JAM;
                    else if (!src_crs)
                        r_next.st = (r_reg.bits < frag && !r_reg.from_exp)
                            ? mprc_pkg::ST_JAM : mprc_pkg::ST_IDLE; // [R06]
                end
            end
            mprc_pkg::ST_JAM:
            begin
                // Jam runs on while any enabled, unpartitioned port remains active
                if (tick)
                begin
                    r_next.tx_dat = ~r_reg.tx_dat;
                    if (r_reg.bits >= frag - BW'(1) && n_live == '0
                        && !(|coll) && exp_col_n_i)
                        r_next.st = mprc_pkg::ST_IDLE; // [R06] [R14]
                end
            end
            mprc_pkg::ST_LOCK:
            begin
                r_next.bits = '0;
                if (tick)
                begin
                    r_next.lock_cnt = r_reg.lock_cnt + 7'h01;
                    if (r_reg.lock_cnt == 7'(mprc_pkg::LOCKOUT_BITS - 1))
                        r_next.st = mprc_pkg::ST_IDLE;
                end
            end
            default:
                r_next.st = mprc_pkg::ST_IDLE;
        endcase
        if (busy && tick && r_reg.bits > BW'(JABBER_BITS))
        begin
            r_next.st = mprc_pkg::ST_LOCK; // [R04]
            r_next.lock_cnt = '0;
        end
        case (r_next.st)
            mprc_pkg::ST_PRE, mprc_pkg::ST_DATA:
                r_next.tx_en = r_next.from_exp ? port_en_i
                    : port_en_i & ~(PORTS'(1) << r_next.src); // [R01] [R08]
            mprc_pkg::ST_JAM:
                r_next.tx_en = port_en_i; // [R14] [R15]
            default:
                r_next.tx_en = '0;
        endcase
        // Active: a port receiving or colliding, or own frame under way
        r_next.req = (n_live != '0) || (|coll) || (!r_next.from_exp
            && r_next.st != mprc_pkg::ST_IDLE
            && r_next.st != mprc_pkg::ST_LOCK); // [R18]
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            r_reg <= '0; // [R16]
            r_reg.st <= mprc_pkg::ST_IDLE;
        end
        else
            r_reg <= r_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign tx_en_o = r_reg.tx_en;
    assign tx_dat_o = {PORTS{r_reg.tx_dat}};
    assign port_partitioned_o = part;
    assign tx_jabber_lockout_o = r_reg.st == mprc_pkg::ST_LOCK; // [R05]
    assign exp_req_n_o = ~r_reg.req; // [R18]
    assign expansion_serial_line_oe_o = r_reg.req && !exp_ack_n_i;
    assign expansion_serial_line_o = r_reg.tx_dat; // [R02]
    assign exp_jam_oe_o = r_reg.req && !exp_ack_n_i;
    assign exp_jam_o = r_reg.st == mprc_pkg::ST_JAM;

    // ****************************************************************
    // Partition units, one per port
    // ****************************************************************
    logic frame_end;
    assign frame_end = busy && !(r_next.st == mprc_pkg::ST_PRE
        || r_next.st == mprc_pkg::ST_DATA || r_next.st == mprc_pkg::ST_JAM);

    for (genvar g = 0; g < PORTS; g++)
    begin : g_port
        mprc_ptn_if lnk ();
        // Free-running tick: partition timing must run while idle too
        assign lnk.bit_tick = r_reg.fdiv; // [R21]
        assign lnk.enabled = port_en_i[g];
        assign lnk.alt = alt_algo_i[g]; // [R20]
        assign lnk.rx_act = rx_crs_i[g] && port_en_i[g];
        assign lnk.sqe = sqe_i[g];
        assign lnk.tx_on = r_reg.tx_en[g];
        assign lnk.collided = col_i[g] && (r_reg.tx_en[g] || rx_crs_i[g]);
        assign lnk.frame_end = frame_end;
        assign part[g] = lnk.partitioned;
        mprc_ptn_unit u_ptn ( // [R13]
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .p(lnk)
        );
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [8:0] lock_cyc_reg;
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            lock_cyc_reg <= '0;
        else if (r_reg.st == mprc_pkg::ST_LOCK)
            lock_cyc_reg <= lock_cyc_reg + 9'h001;
        else
            lock_cyc_reg <= '0;
    end

    a_lock_length: assert property ( // [R04]
        @(posedge clock_i) disable iff (!nrst_i)
        r_reg.st != mprc_pkg::ST_LOCK && $past(r_reg.st) == mprc_pkg::ST_LOCK
        |-> lock_cyc_reg == 9'(LOCK_CYC))
        else $error("jabber lockout length wrong");
    a_jabber_cut: assert property ( // [R04]
        @(posedge clock_i) disable iff (!nrst_i)
        busy && tick && r_reg.bits > BW'(JABBER_BITS)
        |=> r_reg.st == mprc_pkg::ST_LOCK && tx_en_o == '0)
        else $error("jabber did not stop transmitters");
    a_preamble_len: assert property ( // [R03]
        @(posedge clock_i) disable iff (!nrst_i)
        r_reg.st == mprc_pkg::ST_DATA && $past(r_reg.st) == mprc_pkg::ST_PRE
        |-> $past(r_reg.bits) == BW'(mprc_pkg::PREAMBLE_BITS - 1))
        else $error("preamble shorter than required");
    a_frag_extend: assert property ( // [R06]
        @(posedge clock_i) disable iff (!nrst_i)
        r_reg.st == mprc_pkg::ST_IDLE && $past(busy) && !$past(r_reg.from_exp)
        |-> $past(r_reg.bits) >= BW'(mprc_pkg::FRAG_BITS - 1))
        else $error("fragment not extended");
    a_req_active: assert property ( // [R18]
        @(posedge clock_i) disable iff (!nrst_i)
        n_live != '0 |=> !exp_req_n_o)
        else $error("request not raised while receiving");
    a_part_ignored: assert property ( // [R08]
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(r_reg.st == mprc_pkg::ST_PRE)
        |-> $past(live) == (PORTS'(1) << r_reg.src))
        else $error("repeat source not a live port");
endmodule

// file: bench/mprc_xcvr_model.sv
/*
 * Behavioural model of the port transceivers in front of the repeater core.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
module mprc_xcvr_model #(
    parameter int PORTS = 4
) (
    // Clock
    input wire logic clock_i,
    // Receive side of each port
    output logic [PORTS-1:0] rx_crs_o,
    output logic [PORTS-1:0] rx_dat_o,
    output logic [PORTS-1:0] col_o,
    output logic [PORTS-1:0] sqe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PORTS-1:0] dat_q = '0;
    logic [PORTS-1:0] idle_q = '0;

    initial
    begin
        rx_crs_o = '0;
        col_o = '0;
        sqe_o = '0;
    end

    // Idle lines wander so a stale bit is never taken for data
    always @(posedge clock_i)
        idle_q <= #2 ~idle_q;
    assign rx_dat_o = (rx_crs_o & dat_q) | (~rx_crs_o & idle_q);

    // Carrier on port p for nbits bit times; cmask collides from cstart
    task automatic frame(input int p, input int nbits,
        input logic [PORTS-1:0] cmask, input int cstart);
        for (int c = 0; c < 2 * nbits; c++)
        begin
            @(posedge clock_i);
            #2;
            rx_crs_o[p] = 1'h1;
            dat_q[p] = (c / 2) % 3 == 0;
            col_o = (c / 2 >= cstart) ? cmask : '0;
        end
        @(posedge clock_i);
        #2;
        rx_crs_o[p] = 1'h0;
        col_o = '0;
    endtask

    task automatic hold_sqe(input int p, input int nbits);
        @(posedge clock_i);
        #2;
        sqe_o[p] = 1'h1;
        repeat (2 * nbits) @(posedge clock_i);
        #2;
        sqe_o[p] = 1'h0;
    endtask
endmodule

// file: bench/mprc_core_tb.sv
/*
 * Self-checking bench of the repeater core with four ports.
 * Assumes the transceiver model and an expansion arbiter modelled by the bench itself.
 */
module mprc_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NP = 4;
    localparam int JB = 1000;
    logic clock_i;
    logic nrst_i = 1'h0;
    logic [NP-1:0] rx_crs, rx_dat, col, sqe;
    logic [NP-1:0] tx_en_o, tx_dat_o, port_partitioned_o;
    logic [NP-1:0] port_en_i = 4'hf;
    logic [NP-1:0] alt_algo_i = 4'h0;
    logic async_mode_i = 1'h0;
    logic exp_col_n_i = 1'h1;
    logic ext_grant = 1'h0;
    logic tx_jabber_lockout_o, exp_req_n_o, exp_ack_n_i;
    logic ser_o, ser_oe, ser_i, jam_o, jam_oe, jam_i;
    int failures = 0;
    int checked = 0;

    initial
    begin
        clock_i = 1'h0;
        forever #25 clock_i = ~clock_i;
    end

    // The arbiter grants whatever is asked, or grants another device;
    // terminated lines idle low
    assign exp_ack_n_i = exp_req_n_o && !ext_grant;
    assign ser_i = ser_oe ? ser_o : 1'h0;
    assign jam_i = jam_oe & jam_o;

    mprc_xcvr_model #(.PORTS(NP)) xm (.clock_i(clock_i), .rx_crs_o(rx_crs),
        .rx_dat_o(rx_dat), .col_o(col), .sqe_o(sqe));
    mprc_core #(.PORTS(NP), .JABBER_BITS(JB)) dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .rx_crs_i(rx_crs),
        .rx_dat_i(rx_dat), .col_i(col), .sqe_i(sqe), .tx_en_o(tx_en_o),
        .tx_dat_o(tx_dat_o), .port_en_i(port_en_i), .alt_algo_i(alt_algo_i),
        .port_partitioned_o(port_partitioned_o),
        .tx_jabber_lockout_o(tx_jabber_lockout_o),
        .async_mode_i(async_mode_i), .exp_req_n_o(exp_req_n_o),
        .exp_ack_n_i(exp_ack_n_i), .exp_col_n_i(exp_col_n_i),
        .expansion_serial_line_i(ser_i), .expansion_serial_line_o(ser_o),
        .expansion_serial_line_oe_o(ser_oe), .exp_jam_i(jam_i),
        .exp_jam_o(jam_o), .exp_jam_oe_o(jam_oe));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask

    task automatic wait_tx();
        for (int w = 0; w < 50 && tx_en_o === 4'h0; w++)
            cyc(1);
    endtask

    task automatic tx_len(input int p, output int n);
        for (n = 0; n < 3000 && tx_en_o[p] === 1'h1; n++)
            cyc(1);
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < 5000 && (exp_req_n_o !== 1'h1 || tx_en_o !== 4'h0);
            n++)
            cyc(1);
        check(n < 5000, 1);
        cyc(4);
    endtask

    task automatic run_frame(input int p, input int nb,
        input logic [NP-1:0] cm, input int cs);
        xm.frame(p, nb, cm, cs);
        wait_idle();
    endtask

    task automatic complete_run();
        $display("checked %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check(tx_en_o, 4'h0);
        check({exp_req_n_o, tx_jabber_lockout_o}, 2'h2);
        check({port_partitioned_o, ser_oe, jam_oe}, 6'h00);
    endtask

    task automatic t_repeat();
        int bad = 0;
        fork
            xm.frame(1, 150, '0, 0);
            begin
                wait_tx();
                check(tx_en_o, 4'hd);
                check({exp_req_n_o, ser_oe}, 2'h1);
                for (int k = 0; k < 112; k++)
                begin
                    bad += (tx_dat_o[0] !== ~k[1]) || (ser_o !== tx_dat_o[0]);
                    cyc(1);
                end
                check(bad, 0);
            end
        join
        wait_idle();
    endtask

    task automatic t_frag();
        int n;
        for (int am = 0; am < 2; am++)
        begin
            async_mode_i = am[0];
            fork
                xm.frame(0, 10, '0, 0);
                begin
                    wait_tx();
                    tx_len(1, n);
                end
            join
            check(n == 192 || (am == 1 && n == 194), 1);
            wait_idle();
        end
        async_mode_i = 1'h0;
    endtask

    task automatic t_jabber();
        int n;
        int on = 0;
        fork
            xm.frame(0, JB + 150, '0, 0);
            begin
                for (n = 0; n < 2 * JB + 400 && tx_jabber_lockout_o !== 1'h1;
                    n++)
                    cyc(1);
                check(n > 2 * JB, 1);
                for (n = 0; n < 400 && tx_jabber_lockout_o === 1'h1; n++)
                begin
                    on += tx_en_o !== 4'h0;
                    cyc(1);
                end
                check(n, 192);
                check(on, 0);
            end
        join
        wait_idle();
    endtask

    task automatic t_coll();
        int seen = 0;
        fork
            xm.frame(0, 80, '0, 0);
            xm.frame(2, 80, '0, 0);
            for (int i = 0; i < 200; i++)
            begin
                seen += jam_o === 1'h1;
                cyc(1);
            end
        join
        check(seen > 0, 1);
        wait_idle();
        // Arbiter flags a second active device for the whole frame
        exp_col_n_i = 1'h0;
        seen = 0;
        fork
            xm.frame(1, 80, '0, 0);
            for (int i = 0; i < 200; i++)
            begin
                seen += jam_o === 1'h1;
                cyc(1);
            end
        join
        check(seen > 0, 1);
        exp_col_n_i = 1'h1;
        wait_idle();
    endtask

    task automatic t_disable();
        port_en_i = 4'h7;
        fork
            xm.frame(0, 100, '0, 0);
            begin
                wait_tx();
                check(tx_en_o, 4'h6);
            end
        join
        wait_idle();
        port_en_i = 4'hf;
        // Another device holds the bus: its frame reaches every port
        ext_grant = 1'h1;
        cyc(6);
        check({tx_en_o, exp_req_n_o, ser_oe}, 6'h3e);
        ext_grant = 1'h0;
        cyc(4);
        check(tx_en_o, 4'h0);
    endtask

    task automatic t_part();
        for (int i = 1; i <= 32; i++)
        begin
            run_frame(0, 100, 4'h4, 70);
            if (i == 31)
                check(port_partitioned_o, 4'h0);
        end
        check(port_partitioned_o, 4'h4);
        fork
            xm.frame(2, 100, '0, 0);
            begin
                cyc(40);
                check(tx_en_o, 4'h0);
            end
        join
        wait_idle();
        fork
            xm.frame(0, 100, '0, 0);
            begin
                wait_tx();
                check(tx_en_o, 4'he);
            end
        join
        wait_idle();
        run_frame(2, 560, '0, 0);
        check(port_partitioned_o, 4'h0);
    endtask

    task automatic t_alt();
        alt_algo_i = 4'h8;
        xm.hold_sqe(3, 2000);
        cyc(4);
        check(port_partitioned_o, 4'h0);
        xm.hold_sqe(3, 2100);
        cyc(4);
        check(port_partitioned_o, 4'h8);
        run_frame(3, 560, '0, 0);
        check(port_partitioned_o, 4'h8);
        run_frame(0, 560, '0, 0);
        check(port_partitioned_o, 4'h0);
        alt_algo_i = 4'h0;
    endtask

    task automatic t_midreset();
        fork
            xm.frame(0, 300, '0, 0);
            begin
                cyc(100);
                nrst_i = 1'h0;
                cyc(1);
                t_reset();
                nrst_i = 1'h1;
            end
        join
        wait_idle();
    endtask

    initial
    begin
        cyc(5);
        t_reset();
        nrst_i = 1'h1;
        cyc(2);
        t_repeat();
        t_frag();
        t_jabber();
        t_coll();
        t_disable();
        t_part();
        t_alt();
        t_midreset();
        complete_run();
    end

    // The tests need about 23k cycles; cut a hang at over twice that
    initial
    begin
        #3000000;
        failures++;
        complete_run();
    end
endmodule
